// [verilog/sss_pkg.sv]
// Constants, register map and state encoding of the controlled stop sequencer
//
// Overview of operation
// - Ramp-checked mode: at zero-speed limit stop supervision, remove torque, flag it.
// - At zero-speed limit flag completion; acknowledge allowed only after request drops.
// - Brake configured with torque removal: brake engages too when torque drops at zero speed.
// - Negative brake-to-torque-off delay: brake first, torque removal after that delay.
// - Zero or positive delay: brake and torque removal in the same cycle.
// - With brake in use, completion waits brake-to-standstill time from brake engagement.
// - Optional extra delay before torque removal at the zero-speed limit.
// - After acknowledgement release torque removal and stop, clear all three flags.
// - Timed mode: stop request starts timeout counter and raises stop-active flag.
// - Below brake speed limit while ramping, apply delay rule and engage brake/torque.
// - Torque-removed flag rises in the cycle torque removal becomes active.
// - Brake engagement at brake speed limit starts the brake-to-standstill counter.
// - Timeout before braking point removes torque regardless of speed.
// - Standstill counter expiry flags completion; acknowledge once request withdrawn.
// - After acknowledgement release stop, torque removal and brake together, clear flags.
// - Optional extra delay before brake and torque removal at brake speed limit.
// - Zero-speed limit is a configurable threshold for torque removal and completion.
// - Ramp-checked mode: speed outside either ramp limit removes torque immediately.
package sss_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int SPEED_W = 16;

    // Word offsets on the register port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ZERO_SPEED = 4'h1;
    localparam logic [3:0] REG_BRAKE_SPEED = 4'h2;
    localparam logic [3:0] REG_RAMP_LOWER = 4'h3;
    localparam logic [3:0] REG_RAMP_UPPER = 4'h4;
    localparam logic [3:0] REG_STOP_TIMEOUT = 4'h5;
    localparam logic [3:0] REG_EXTRA_DELAY = 4'h6;
    localparam logic [3:0] REG_BRAKE_TO_DELAY = 4'h7;
    localparam logic [3:0] REG_STANDSTILL = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'h9;
    localparam int CFG_N = 9;

    // Control register fields
    localparam int CTRL_RAMP_CHECKED = 0;
    localparam int CTRL_BRAKE_IN_TO = 1;
    localparam int CTRL_BRAKE_AT_SPEED = 2;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // Status register fields
    localparam int STAT_ACTIVE = 0;
    localparam int STAT_COMPLETED = 1;
    localparam int STAT_TORQUE_OFF = 2;
    localparam int STAT_BRAKE = 3;
    localparam int STAT_TRIPPED = 4;
    localparam int STAT_STATE_LSB = 8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RAMP = 3'b001,
        ST_EXTRA = 3'b010,
        ST_LEAD = 3'b011,
        ST_HOLD = 3'b100,
        ST_DONE = 3'b101
    } sss_state_t;

endpackage : sss_pkg

// [verilog/sss_sequencer.sv]
// Controlled stop sequencer: ramp supervision, brake and torque removal, acknowledge
`timescale 1ns/1ps

module sss_sequencer
    import sss_pkg::*;
(
    input wire logic core_clk, // System clock, 100 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire logic [ADDR_W-1:0] regAddr, // Register word offset
    input wire logic [DATA_W-1:0] regWrData, // Register write data
    input wire logic regWrStb, // Register write strobe
    input wire logic regRdStb, // Register read strobe
    output logic [DATA_W-1:0] regRdData, // Read data, cycle after strobe
    input wire logic stopRequest, // Controlled stop request level
    input wire logic stopAck, // Acknowledge pulse
    input wire logic [SPEED_W-1:0] motorSpeed, // Motor speed magnitude from drive
    output logic driveRampDown, // Drive shall ramp down
    output logic driveModulateEn, // Drive may modulate
    output logic torqueRemoval, // Torque removal active
    output logic brakeControl, // Mechanical brake engaged
    output logic stopActiveFlag, // Stop function active
    output logic stopCompletedFlag, // Stop function completed
    output logic torqueRemovedFlag // Torque removed indication
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    sss_state_t state_reg;
    sss_state_t state_next;
    logic [DATA_W-1:0] cfg_reg [CFG_N];
    logic [DATA_W-1:0] cfg_next [CFG_N];
    logic [DATA_W-1:0] rdData_reg;
    logic [DATA_W-1:0] rdData_next;
    logic [DATA_W-1:0] timeoutCnt_reg;
    logic [DATA_W-1:0] timeoutCnt_next;
    logic [DATA_W-1:0] phaseCnt_reg;
    logic [DATA_W-1:0] phaseCnt_next;
    logic [DATA_W-1:0] standCnt_reg;
    logic [DATA_W-1:0] standCnt_next;
    logic active_reg;
    logic active_next;
    logic done_reg;
    logic done_next;
    logic torqueOff_reg;
    logic torqueOff_next;
    logic brake_reg;
    logic brake_next;
    logic tripped_reg;
    logic tripped_next;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration decode

    logic rampChecked;
    logic brakeInTo;
    logic brakeAtSpeed;
    logic useBrake;
    logic [SPEED_W-1:0] zeroLimit;
    logic [SPEED_W-1:0] brakeLimit;
    logic [SPEED_W-1:0] rampLower;
    logic [SPEED_W-1:0] rampUpper;
    logic [SPEED_W-1:0] trigLimit;
    logic [DATA_W-1:0] brakeDelay;
    logic [DATA_W-1:0] leadCycles;
    logic delayNegative;
    logic timeoutExpired;
    logic rampViolation;
    logic [DATA_W-1:0] statusWord;

    assign rampChecked = cfg_reg[REG_CTRL][CTRL_RAMP_CHECKED];
    assign brakeInTo = cfg_reg[REG_CTRL][CTRL_BRAKE_IN_TO];
    assign brakeAtSpeed = cfg_reg[REG_CTRL][CTRL_BRAKE_AT_SPEED];
    assign useBrake = brakeInTo | brakeAtSpeed;
    assign zeroLimit = cfg_reg[REG_ZERO_SPEED][SPEED_W-1:0];
    assign brakeLimit = cfg_reg[REG_BRAKE_SPEED][SPEED_W-1:0];
    assign rampLower = cfg_reg[REG_RAMP_LOWER][SPEED_W-1:0];
    assign rampUpper = cfg_reg[REG_RAMP_UPPER][SPEED_W-1:0];
    assign brakeDelay = cfg_reg[REG_BRAKE_TO_DELAY];
    // Delay is two's complement; a negative value is the brake lead in cycles
    assign delayNegative = brakeDelay[DATA_W-1];
    assign leadCycles = DATA_W'(-brakeDelay);
    // Speed-triggered braking moves the trigger up to the brake speed limit
    assign trigLimit = brakeAtSpeed ? brakeLimit : zeroLimit;
    assign timeoutExpired = !rampChecked && (timeoutCnt_reg == 32'h0000_0000);
    assign rampViolation = rampChecked && (motorSpeed > rampUpper || motorSpeed < rampLower);

    assign statusWord = {
        21'h00_0000, state_reg, 3'h0, tripped_reg, brake_reg,
        torqueOff_reg, done_reg, active_reg
    };

    ////////////////////////////////////////////////////////////////////////////
    // Register port

    always_comb
    begin
        for (int i = 0; i < CFG_N; i++)
        begin
            cfg_next[i] = cfg_reg[i];
        end
        rdData_next = 32'h0000_0000;
        if (regWrStb && regAddr < REG_STATUS)
        begin
            cfg_next[regAddr] = regWrData;
        end
        // Read data stands for one cycle only; unmapped offsets read zero
        if (regRdStb)
        begin
            if (regAddr < REG_STATUS)
            begin
                rdData_next = cfg_reg[regAddr];
            end
            else if (regAddr == REG_STATUS)
            begin
                rdData_next = statusWord;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < CFG_N; i++)
            begin
                cfg_reg[i] <= CFG_RESET;
            end
            rdData_reg <= 32'h0000_0000;
        end
        else
        begin
            cfg_reg <= cfg_next;
            rdData_reg <= rdData_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stop sequence

    always_comb
    begin
        state_next = state_reg;
        timeoutCnt_next = timeoutCnt_reg;
        phaseCnt_next = phaseCnt_reg;
        standCnt_next = standCnt_reg;
        active_next = active_reg;
        done_next = done_reg;
        torqueOff_next = torqueOff_reg;
        brake_next = brake_reg;
        tripped_next = tripped_reg;

        if (timeoutCnt_reg != 32'h0000_0000)
        begin
            timeoutCnt_next = timeoutCnt_reg - 32'h0000_0001;
        end
        // Standstill time runs from brake engagement, also through the brake lead
        if (brake_reg && standCnt_reg != 32'h0000_0000)
        begin
            standCnt_next = standCnt_reg - 32'h0000_0001;
        end

        unique case (state_reg)
            ST_IDLE:
            begin
                if (stopRequest)
                begin
                    active_next = 1'b1;
                    timeoutCnt_next = cfg_reg[REG_STOP_TIMEOUT];
                    state_next = ST_RAMP;
                end
            end
            ST_RAMP:
            begin
                if (timeoutExpired)
                begin
                    torqueOff_next = 1'b1;
                    tripped_next = 1'b1;
                    state_next = ST_HOLD;
                end
                else if (motorSpeed <= trigLimit)
                begin
                    // Supervision ends here, before any ramp limit is looked at
                    phaseCnt_next = cfg_reg[REG_EXTRA_DELAY];
                    state_next = ST_EXTRA;
                end
                else if (rampViolation)
                begin
                    torqueOff_next = 1'b1;
                    tripped_next = 1'b1;
                    state_next = ST_HOLD;
                end
            end
            ST_EXTRA:
            begin
                if (timeoutExpired)
                begin
                    torqueOff_next = 1'b1;
                    tripped_next = 1'b1;
                    state_next = ST_HOLD;
                end
                else if (phaseCnt_reg != 32'h0000_0000)
                begin
                    phaseCnt_next = phaseCnt_reg - 32'h0000_0001;
                end
                else if (useBrake)
                begin
                    brake_next = 1'b1;
                    standCnt_next = cfg_reg[REG_STANDSTILL];
                    if (delayNegative && leadCycles != 32'h0000_0000)
                    begin
                        phaseCnt_next = leadCycles;
                        state_next = ST_LEAD;
                    end
                    else
                    begin
                        torqueOff_next = 1'b1;
                        state_next = ST_HOLD;
                    end
                end
                else
                begin
                    torqueOff_next = 1'b1;
                    state_next = ST_HOLD;
                end
            end
            ST_LEAD:
            begin
                if (phaseCnt_reg == 32'h0000_0001)
                begin
                    torqueOff_next = 1'b1;
                    state_next = ST_HOLD;
                end
                phaseCnt_next = phaseCnt_reg - 32'h0000_0001;
            end
            ST_HOLD:
            begin
                // A tripped stop completes only once the coasting motor is slow enough
                if (brake_reg ? (standCnt_reg == 32'h0000_0000)
                              : (!tripped_reg || motorSpeed <= zeroLimit))
                begin
                    done_next = 1'b1;
                    state_next = ST_DONE;
                end
            end
            ST_DONE:
            begin
                // Torque removal holds here until the request is gone and acked
                if (stopAck && !stopRequest)
                begin
                    active_next = 1'b0;
                    done_next = 1'b0;
                    torqueOff_next = 1'b0;
                    brake_next = 1'b0;
                    tripped_next = 1'b0;
                    timeoutCnt_next = 32'h0000_0000;
                    phaseCnt_next = 32'h0000_0000;
                    standCnt_next = 32'h0000_0000;
                    state_next = ST_IDLE;
                end
            end
            default:
            begin
                // Unused codes fail safe with torque removed
                torqueOff_next = 1'b1;
                tripped_next = 1'b1;
                active_next = 1'b1;
                state_next = ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            timeoutCnt_reg <= 32'h0000_0000;
            phaseCnt_reg <= 32'h0000_0000;
            standCnt_reg <= 32'h0000_0000;
            active_reg <= 1'b0;
            done_reg <= 1'b0;
            torqueOff_reg <= 1'b0;
            brake_reg <= 1'b0;
            tripped_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            timeoutCnt_reg <= timeoutCnt_next;
            phaseCnt_reg <= phaseCnt_next;
            standCnt_reg <= standCnt_next;
            active_reg <= active_next;
            done_reg <= done_next;
            torqueOff_reg <= torqueOff_next;
            brake_reg <= brake_next;
            tripped_reg <= tripped_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign regRdData = rdData_reg;
    // The drive picks its ramp itself; this only tells it to ramp
    assign driveRampDown = active_reg && !torqueOff_reg;
    assign driveModulateEn = !torqueOff_reg;
    assign torqueRemoval = torqueOff_reg;
    assign torqueRemovedFlag = torqueOff_reg;
    assign brakeControl = brake_reg;
    assign stopActiveFlag = active_reg;
    assign stopCompletedFlag = done_reg;

endmodule : sss_sequencer

// [tb/sss_checker_sva.sv]
// Concurrent checks on the controlled stop sequencer ports
`timescale 1ns/1ps

module sss_checker
    import sss_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic rst, // Reset
    input wire logic regRdStb, // Read strobe
    input wire logic [DATA_W-1:0] regRdData, // Read data
    input wire logic stopRequest, // Stop request
    input wire logic stopAck, // Acknowledge
    input wire logic driveRampDown, // Ramp command
    input wire logic driveModulateEn, // Modulation enable
    input wire logic torqueRemoval, // Torque off
    input wire logic brakeControl, // Brake
    input wire logic stopActiveFlag, // Active flag
    input wire logic stopCompletedFlag, // Completed flag
    input wire logic torqueRemovedFlag // Torque off flag
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // An accepted acknowledge ends the sequence
    logic ackOk;
    assign ackOk = stopCompletedFlag && stopAck && !stopRequest;

    ////////////////////////////////////////////////////////////////////////////////
    a_modulate_follows: assert property (driveModulateEn == !torqueRemoval)
        else $error("modulate enable not inverse of torque off");
    a_flag_with_torque: assert property (torqueRemovedFlag == torqueRemoval)
        else $error("torque flag differs from torque off");
    a_ramp_until_off: assert property (driveRampDown == (stopActiveFlag && !torqueRemoval))
        else $error("ramp command wrong");
    a_active_cause: assert property ($rose(stopActiveFlag) |-> $past(stopRequest))
        else $error("stop active without request");
    a_torque_held: assert property (torqueRemoval && !ackOk |=> torqueRemoval)
        else $error("torque off dropped without acknowledge");
    a_brake_held: assert property (brakeControl && !ackOk |=> brakeControl)
        else $error("brake dropped without acknowledge");
    a_ack_clears: assert property (ackOk |=> !stopActiveFlag && !stopCompletedFlag
        && !torqueRemoval && !brakeControl)
        else $error("acknowledge did not clear the sequence");
    a_ack_ignored: assert property (stopCompletedFlag && stopRequest |=> stopCompletedFlag)
        else $error("completion lost while request high");
    a_done_torque: assert property (stopCompletedFlag |-> torqueRemoval && stopActiveFlag)
        else $error("completion without torque off");
    a_read_idle: assert property (!$past(regRdStb) |-> regRdData == 32'h0)
        else $error("read data outside read cycle");
endmodule : sss_checker

bind sss_sequencer sss_checker i_chk (.core_clk(core_clk), .rst(rst), .regRdStb(regRdStb),
    .regRdData(regRdData), .stopRequest(stopRequest), .stopAck(stopAck),
    .driveRampDown(driveRampDown), .driveModulateEn(driveModulateEn),
    .torqueRemoval(torqueRemoval), .brakeControl(brakeControl),
    .stopActiveFlag(stopActiveFlag), .stopCompletedFlag(stopCompletedFlag),
    .torqueRemovedFlag(torqueRemovedFlag));

// [tb/sss_drive_model.sv]
// Drive controller model: ramps down on command, coasts while torque is off
`timescale 1ns/1ps

module sss_drive_model #(
    parameter int RESP_CYC = 2
)
(
    input wire logic core_clk, // Clock
    input wire logic rst, // Reset
    input wire logic driveRampDown, // Ramp command
    input wire logic driveModulateEn, // Modulation enable
    input wire logic [15:0] rampSetting, // Module ramp step, 0 selects own
    input wire logic [15:0] ownRamp, // Drive ramp step, also coast rate
    input wire logic loadEn, // Load start speed
    input wire logic [15:0] loadSpeed, // Start speed
    output logic [15:0] motorSpeed // Speed magnitude
);
    int respCnt;
    logic [15:0] step;

    assign step = (rampSetting == 16'h0) ? ownRamp : rampSetting;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            motorSpeed <= 16'h0;
            respCnt <= 0;
        end
        else
        begin
            // Response time passes before the ramp starts
            respCnt <= driveRampDown ? ((respCnt < RESP_CYC) ? respCnt + 1 : respCnt) : 0;
            if (loadEn)
                motorSpeed <= loadSpeed;
            else if (driveRampDown && respCnt == RESP_CYC)
                motorSpeed <= (motorSpeed > step) ? motorSpeed - step : 16'h0;
            else if (!driveModulateEn)
                motorSpeed <= (motorSpeed > ownRamp) ? motorSpeed - ownRamp : 16'h0;
        end
    end
endmodule : sss_drive_model

// [tb/sss_sequencer_tb.sv]
// Self-checking bench of the controlled stop sequencer
`timescale 1ns/1ps

module sss_sequencer_tb
    import sss_pkg::*;
();
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic stopRequest = 1'b0;
    logic stopAck = 1'b0;
    logic [15:0] rampSetting = 16'h0;
    logic loadEn = 1'b0;
    logic [15:0] loadSpeed = 16'h0;
    logic [DATA_W-1:0] regRdData;
    logic [SPEED_W-1:0] motorSpeed;
    logic driveRampDown, driveModulateEn, torqueRemoval, brakeControl;
    logic stopActiveFlag, stopCompletedFlag, torqueRemovedFlag;
    int fails = 0;
    int cmp_count = 0;
    int now = 0;
    int tReq;
    int dA;
    // Edge of first sight: 0 active, 1 trigger, 2 brake, 3 torque off, 4 completed
    int tm [0:4];
    logic [31:0] rv;

    sss_sequencer i_dut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .stopRequest(stopRequest), .stopAck(stopAck),
        .motorSpeed(motorSpeed), .driveRampDown(driveRampDown),
        .driveModulateEn(driveModulateEn), .torqueRemoval(torqueRemoval),
        .brakeControl(brakeControl), .stopActiveFlag(stopActiveFlag),
        .stopCompletedFlag(stopCompletedFlag), .torqueRemovedFlag(torqueRemovedFlag));

    sss_drive_model i_drive (.core_clk(core_clk), .rst(rst), .driveRampDown(driveRampDown),
        .driveModulateEn(driveModulateEn), .rampSetting(rampSetting), .ownRamp(16'h00c8),
        .loadEn(loadEn), .loadSpeed(loadSpeed), .motorSpeed(motorSpeed));

    initial
    begin
        forever #5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick();
        @(posedge core_clk);
        now++;
    endtask : tick

    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(logic [3:0] a, logic [31:0] d);
        tick();
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        tick();
        regWrStb <= 1'b0;
    endtask : wr

    task automatic rd(logic [3:0] a);
        tick();
        regAddr <= a;
        regRdStb <= 1'b1;
        tick();
        regRdStb <= 1'b0;
        #1;
        rv = regRdData;
    endtask : rd

    // One stop sequence, from configuration to the accepted acknowledge
    task automatic run(logic [2:0] ctrl, logic [31:0] dly, int e, int s, int t,
        logic [15:0] up, logic [15:0] ramp);
        logic [31:0] cfg [1:8];
        logic [15:0] lim;
        cfg = '{32'h64, 32'h190, 32'h0, {16'h0, up}, t, e, dly, s};
        lim = ctrl[2] ? 16'h190 : 16'h64;
        for (int i = 1; i <= 8; i++)
            wr(4'(i), cfg[i]);
        wr(REG_CTRL, {29'h0, ctrl});
        rampSetting <= ramp;
        loadSpeed <= 16'h03e8;
        loadEn <= 1'b1;
        tick();
        loadEn <= 1'b0;
        stopRequest <= 1'b1;
        tReq = now + 1;
        tm = '{default: -1};
        for (int i = 0; i < 400 && tm[4] < 0; i++)
        begin
            tick();
            #1;
            if (tm[0] < 0 && stopActiveFlag === 1'b1) tm[0] = now;
            if (tm[1] < 0 && motorSpeed <= lim) tm[1] = now + 1;
            if (tm[2] < 0 && brakeControl === 1'b1) tm[2] = now;
            if (tm[3] < 0 && torqueRemoval === 1'b1) tm[3] = now;
            if (tm[4] < 0 && stopCompletedFlag === 1'b1) tm[4] = now;
        end
        chk(tm[0] - tReq, 0);
        // Request still high, so the sequence must sit in its completed state
        rd(REG_STATUS);
        chk({rv[10:8], rv[3:0]}, {ST_DONE, |ctrl[2:1], 3'b111});
        tick();
        stopAck <= 1'b1;
        tick();
        stopAck <= 1'b0;
        #1;
        chk(stopCompletedFlag, 1'b1);
        tick();
        stopRequest <= 1'b0;
        tick();
        stopAck <= 1'b1;
        tick();
        stopAck <= 1'b0;
        #1;
        chk({stopActiveFlag, stopCompletedFlag, torqueRemovedFlag, brakeControl,
            driveModulateEn}, 5'b00001);
    endtask : run

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        chk({torqueRemoval, brakeControl, stopActiveFlag, driveModulateEn}, 4'b0001);
        wr(REG_STATUS, 32'h1f);
        rd(REG_STATUS);
        chk(rv, 32'h0);
        wr(REG_EXTRA_DELAY, 32'h5);
        rd(REG_EXTRA_DELAY);
        chk(rv, 32'h5);
        rd(4'ha);
        chk(rv, 32'h0);
        run(3'b001, 32'h0, 0, 0, 1000, 16'hffff, 16'h0);
        dA = tm[3] - tm[1];
        chk(dA == 1 || dA == 2, 1'b1);
        chk(tm[4] - tm[3], 1);
        chk(tm[2], 32'hffffffff);
        run(3'b001, 32'h0, 3, 0, 1000, 16'hffff, 16'h0064);
        chk(tm[3] - tm[1] - dA, 3);
        run(3'b011, 32'h0, 0, 4, 1000, 16'hffff, 16'h0);
        chk(tm[3] - tm[2], 0);
        chk(tm[4] - tm[2], 5);
        run(3'b101, 32'hfffffffd, 2, 6, 1000, 16'hffff, 16'h0);
        chk(tm[3] - tm[2], 3);
        chk(tm[4] - tm[2], 7);
        chk(tm[2] - tm[1] - dA, 2);
        run(3'b000, 32'h0, 0, 0, 5, 16'hffff, 16'h0001);
        chk(tm[3] - tReq, 6);
        chk(tm[2], 32'hffffffff);
        run(3'b001, 32'h0, 0, 0, 1000, 16'h01f4, 16'h0);
        chk(tm[3] - tReq <= 2, 1'b1);
        finish_test();
    end

    initial
    begin
        #200000;
        fails++;
        finish_test();
    end
endmodule : sss_sequencer_tb
